// >>> hdl/swst_pkg.sv
// constants and types of the single-wire search triplet sequencer
package swst_pkg;
    // ---------------------------------------------------------------
    // clock and timing
    // ---------------------------------------------------------------
    localparam int CLK_PERIOD_PS = 40000;
    localparam int ACT_DELAY_PS = 262500;
    localparam int ACT_DELAY_CYC = (ACT_DELAY_PS / CLK_PERIOD_PS < 1) ? 1 :
        ACT_DELAY_PS / CLK_PERIOD_PS;
    localparam int STD_W1L_NS = 6000;
    localparam int STD_MSR_NS = 12000;
    localparam int STD_SLOT_NS = 70000;
    localparam int OD_W1L_NS = 1000;
    localparam int OD_MSR_NS = 2000;
    localparam int OD_SLOT_NS = 10000;
    localparam int PULLUP_NS = 2000;
    localparam int STD_W1L_CYC = (STD_W1L_NS * 1000 + 39999) / 40000;
    localparam int STD_MSR_CYC = (STD_MSR_NS * 1000 + 39999) / 40000;
    localparam int STD_SLOT_CYC = (STD_SLOT_NS * 1000 + 39999) / 40000;
    localparam int OD_W1L_CYC = (OD_W1L_NS * 1000 + 39999) / 40000;
    localparam int OD_MSR_CYC = (OD_MSR_NS * 1000 + 39999) / 40000;
    localparam int OD_SLOT_CYC = (OD_SLOT_NS * 1000 + 39999) / 40000;
    localparam int PULLUP_CYC = (PULLUP_NS * 1000 + 39999) / 40000;
    localparam int CNT_W = 13;
    // ---------------------------------------------------------------
    // command codes
    // ---------------------------------------------------------------
    localparam logic [7:0] CMD_TRIPLET = 8'h78;
    localparam int DIR_BIT = 7;
    // ---------------------------------------------------------------
    // register map and fields
    // ---------------------------------------------------------------
    localparam logic [7:0] ADDR_CTRL = 8'h00;
    localparam logic [7:0] ADDR_TIMING = 8'h04;
    localparam logic [7:0] ADDR_TIMING2 = 8'h08;
    localparam logic [7:0] ADDR_STATUS = 8'h0C;
    localparam int CTRL_OD = 0;
    localparam int CTRL_ACT_PU = 1;
    localparam int CTRL_PAS_PU = 2;
    localparam int TIM_W0L_LSB = 0;
    localparam int TIM_REC_LSB = 16;
    localparam int TIM2_RSTL_LSB = 0;
    localparam int TIM2_MSP_LSB = 16;
    localparam int ST_BUSY = 0;
    localparam int ST_FIRST = 5;
    localparam int ST_SECOND = 6;
    localparam int ST_DIR = 7;
    localparam logic [11:0] W0L_RST = 12'h5DC;
    localparam logic [11:0] REC_RST = 12'h07D;
    localparam logic [15:0] RSTL_RST = 16'h3A98;
    localparam logic [15:0] MSP_RST = 16'h0708;
    // ---------------------------------------------------------------
    // types
    // ---------------------------------------------------------------
    typedef struct packed {
        logic overdrive_speed_select;
        logic active_pullup_enable;
        logic passive_pullup_select;
        logic [11:0] write_zero_low_time;
        logic [11:0] recovery_time;
        logic [15:0] reset_low_time;
        logic [15:0] presence_sample_time;
    } swst_cfg_type;
    typedef struct packed {
        logic chosen_dir;
        logic triplet_second_bit;
        logic single_bit_result;
        logic line_busy_flag;
    } swst_status_type;
    typedef enum logic [1:0] {
        ST_IDLE = 2'b01,
        ST_RUN = 2'b10
    } swst_state_type;
endpackage

// >>> hdl/swst_triplet.sv
// search triplet command sequencer with apb registers
// Behaviour
// [R1] triplet is code 78h plus exactly one direction byte in one write
// [R2] accepted triplet drives two read slots then one write slot
// [R3] both reads 0: write bit 7 of direction byte, rest ignored
// [R4] reads 0 then 1: write a zero slot
// [R5] reads 1 then 0: write a one slot
// [R6] reads both 1: still finish with a one slot
// [R7] busy at code: nack code and parameter, drop command
// [R8] triplet ends within three slots plus 262.5ns after msb edge
// [R9] line activity starts within 262.5ns of parameter msb edge
// [R10] after triplet the read pointer selects the status register
// [R11] busy flag is high through the three slots, then clears
// [R12] single bit result updates at first read sample instant
// [R13] second bit and chosen path update at second sample instant
// [R14] current timing and pullup settings apply to the triplet
// [R15] host repeats the triplet 64 times for a full search
// [R16] host addresses the device for write before the code
// [R17] surplus bytes and invalid bytes are never acknowledged
// [R18] each read byte returns the pointed register for polling
// [R19] chosen path equals written bit, second bit equals read two
// [R20] speed and active pullup settings apply to all three slots
`timescale 1ns/100ps
module swst_triplet #(
    parameter int ADDR_W = 8
) (
    // clock and reset
    input wire logic clk_in,
    input wire logic reset_in,
    // apb slave
    input wire logic psel_in,
    input wire logic penable_in,
    input wire logic pwrite_in,
    input wire logic [ADDR_W-1:0] paddr_in,
    input wire logic [31:0] pwdata_in,
    output logic [31:0] prdata_out,
    output logic pready_out,
    output logic pslverr_out,
    // byte side of the serial host engine
    input wire logic host_start_in,
    input wire logic host_write_in,
    input wire logic host_msb_in,
    input wire logic host_msb_bit_in,
    input wire logic host_byte_in,
    input wire logic [7:0] host_data_in,
    output logic host_ack_out,
    output logic [7:0] read_data_out,
    output logic read_ptr_status_out,
    // single-wire line
    input wire logic line_in,
    output logic line_out,
    output logic line_oe_out,
    output logic passive_pullup_select_out,
    output swst_pkg::swst_status_type status_out
);
    import swst_pkg::*;

    // ---------------------------------------------------------------
    // declarations
    // ---------------------------------------------------------------
    swst_cfg_type cfg_reg;
    swst_status_type status_reg;
    swst_state_type state_reg;
    logic [1:0] phase_reg;
    logic [1:0] slot_reg;
    logic [CNT_W-1:0] cnt_reg;
    logic dir_pref_reg;
    logic ptr_status_reg;
    logic [31:0] prdata_reg;
    logic code_ok;
    logic start_run;
    logic sample_now;
    logic slot_end;
    logic [CNT_W-1:0] low_len;
    logic [CNT_W-1:0] msr_len;
    logic [CNT_W-1:0] end_len;
    logic [CNT_W-1:0] rec_end;
    logic [CNT_W-1:0] slot_len;
    logic pullup_phase;
    logic low_phase;
    logic map_hit;

    localparam logic [1:0] PH_CODE = 2'h0;
    localparam logic [1:0] PH_PARAM = 2'h1;
    localparam logic [1:0] PH_DROP = 2'h2;
    localparam logic [1:0] PH_SURPLUS = 2'h3;

    // chosen path from two read results and the preferred bit
    function automatic logic choose_dir(input logic first, input logic second,
                                        input logic pref);
        if (first != second) begin
            choose_dir = first;
        end else if (first) begin
            choose_dir = 1'b1;
        end else begin
            choose_dir = pref;
        end
    endfunction

    // status register as the host sees it
    function automatic logic [7:0] status_byte(input swst_status_type st);
        status_byte = 8'h00;
        status_byte[ST_BUSY] = st.line_busy_flag;
        status_byte[ST_FIRST] = st.single_bit_result;
        status_byte[ST_SECOND] = st.triplet_second_bit;
        status_byte[ST_DIR] = st.chosen_dir;
    endfunction

    // ---------------------------------------------------------------
    // host byte decode
    // ---------------------------------------------------------------
    assign code_ok = host_write_in && host_data_in == CMD_TRIPLET;
    // [R9] launch at msb edge
    assign start_run = host_msb_in && host_write_in &&
                       phase_reg == PH_PARAM && state_reg == ST_IDLE &&
                       !status_reg.line_busy_flag;

    always_comb begin
        host_ack_out = 1'b0;
        if (host_byte_in && host_write_in) begin
            case (phase_reg)
                // [R7] refuse code while busy
                PH_CODE: host_ack_out = code_ok &&
                                        !status_reg.line_busy_flag;
                // [R1] one parameter byte
                PH_PARAM: host_ack_out = 1'b1;
                // [R17] no ack for extras
                default: host_ack_out = 1'b0;
            endcase
        end
    end

    // [R1] byte position tracking
    always_ff @(posedge clk_in) begin
        if (reset_in || host_start_in) begin
            phase_reg <= PH_CODE;
        end else if (host_byte_in && host_write_in) begin
            case (phase_reg)
                PH_CODE: begin
                    if (!code_ok) begin
                        phase_reg <= PH_SURPLUS;
                    end else if (status_reg.line_busy_flag) begin
                        phase_reg <= PH_DROP;
                    end else begin
                        phase_reg <= PH_PARAM;
                    end
                end
                default: phase_reg <= PH_SURPLUS;
            endcase
        end
    end

    // [R10] pointer to status
    always_ff @(posedge clk_in) begin
        if (reset_in) begin
            ptr_status_reg <= 1'b1;
        end else if (host_byte_in && phase_reg == PH_CODE && code_ok &&
                     !status_reg.line_busy_flag) begin
            ptr_status_reg <= 1'b1;
        end
    end

    // [R18] pointed register on every byte
    always_ff @(posedge clk_in) begin
        if (reset_in) begin
            read_data_out <= 8'h00;
        end else begin
            read_data_out <= ptr_status_reg ? status_byte(status_reg) : 8'h00;
        end
    end

    // ---------------------------------------------------------------
    // slot timing
    // ---------------------------------------------------------------
    // [R20] speed select for every slot
    assign msr_len = cfg_reg.overdrive_speed_select ? CNT_W'(OD_MSR_CYC) :
                     CNT_W'(STD_MSR_CYC);
    assign slot_len = cfg_reg.overdrive_speed_select ? CNT_W'(OD_SLOT_CYC) :
                      CNT_W'(STD_SLOT_CYC);

    always_comb begin
        low_len = cfg_reg.overdrive_speed_select ? CNT_W'(OD_W1L_CYC) :
                  CNT_W'(STD_W1L_CYC);
        // [R14] live write-zero low time
        if (slot_reg == 2'd2 && !status_reg.chosen_dir) begin
            low_len = CNT_W'(cfg_reg.write_zero_low_time);
        end
    end

    // [R14] live recovery time
    assign rec_end = low_len + CNT_W'(cfg_reg.recovery_time);
    // [R8] bounded slot length
    assign end_len = (rec_end > slot_len) ? rec_end : slot_len;
    assign sample_now = state_reg == ST_RUN && slot_reg != 2'd2 &&
                        cnt_reg == msr_len;
    assign slot_end = state_reg == ST_RUN && cnt_reg == end_len - 1'b1;
    assign low_phase = state_reg == ST_RUN && cnt_reg < low_len;
    // [R20] active pullup after each release
    assign pullup_phase = state_reg == ST_RUN &&
                          cfg_reg.active_pullup_enable && !low_phase &&
                          cnt_reg < low_len + CNT_W'(PULLUP_CYC);

    assign line_oe_out = low_phase || pullup_phase;
    assign line_out = pullup_phase;
    assign passive_pullup_select_out = cfg_reg.passive_pullup_select;

    // [R2] two reads then one write
    always_ff @(posedge clk_in) begin
        if (reset_in) begin
            state_reg <= ST_IDLE;
            slot_reg <= 2'd0;
            cnt_reg <= '0;
        end else begin
            case (state_reg)
                ST_IDLE: begin
                    cnt_reg <= '0;
                    slot_reg <= 2'd0;
                    if (start_run) begin
                        state_reg <= ST_RUN;
                    end
                end
                ST_RUN: begin
                    if (slot_end) begin
                        cnt_reg <= '0;
                        slot_reg <= slot_reg + 2'd1;
                        if (slot_reg == 2'd2) begin
                            state_reg <= ST_IDLE;
                        end
                    end else begin
                        cnt_reg <= cnt_reg + 1'b1;
                    end
                end
                default: state_reg <= ST_IDLE;
            endcase
        end
    end

    always_ff @(posedge clk_in) begin
        if (reset_in) begin
            dir_pref_reg <= 1'b0;
        end else if (start_run) begin
            // [R3] only bit 7 matters
            dir_pref_reg <= host_msb_bit_in;
        end
    end

    // ---------------------------------------------------------------
    // status flags
    // ---------------------------------------------------------------
    always_ff @(posedge clk_in) begin
        if (reset_in) begin
            status_reg <= '0;
        end else begin
            // [R11] busy across three slots
            if (start_run) begin
                status_reg.line_busy_flag <= 1'b1;
            end else if (slot_end && slot_reg == 2'd2) begin
                status_reg.line_busy_flag <= 1'b0;
            end
            // [R12] first sample result
            if (sample_now && slot_reg == 2'd0) begin
                status_reg.single_bit_result <= line_in;
            end
            // [R13] second sample results
            if (sample_now && slot_reg == 2'd1) begin
                // [R19] second read kept
                status_reg.triplet_second_bit <= line_in;
                // [R4] [R5] [R6] path choice
                status_reg.chosen_dir <= choose_dir(
                    status_reg.single_bit_result, line_in, dir_pref_reg);
            end
        end
    end
    assign status_out = status_reg;
    assign read_ptr_status_out = ptr_status_reg;

    // ---------------------------------------------------------------
    // apb registers
    // ---------------------------------------------------------------
    assign map_hit = paddr_in == ADDR_W'(ADDR_CTRL) ||
                     paddr_in == ADDR_W'(ADDR_TIMING) ||
                     paddr_in == ADDR_W'(ADDR_TIMING2) ||
                     paddr_in == ADDR_W'(ADDR_STATUS);
    assign pready_out = 1'b1;
    assign pslverr_out = psel_in && penable_in && !map_hit;
    assign prdata_out = prdata_reg;

    always_ff @(posedge clk_in) begin
        if (reset_in) begin
            cfg_reg <= '0;
            cfg_reg.write_zero_low_time <= W0L_RST;
            cfg_reg.recovery_time <= REC_RST;
            cfg_reg.reset_low_time <= RSTL_RST;
            cfg_reg.presence_sample_time <= MSP_RST;
        end else if (psel_in && penable_in && pwrite_in) begin
            case (paddr_in)
                ADDR_W'(ADDR_CTRL): begin
                    cfg_reg.overdrive_speed_select <= pwdata_in[CTRL_OD];
                    cfg_reg.active_pullup_enable <= pwdata_in[CTRL_ACT_PU];
                    cfg_reg.passive_pullup_select <= pwdata_in[CTRL_PAS_PU];
                end
                ADDR_W'(ADDR_TIMING): begin
                    cfg_reg.write_zero_low_time <=
                        pwdata_in[TIM_W0L_LSB +: 12];
                    cfg_reg.recovery_time <= pwdata_in[TIM_REC_LSB +: 12];
                end
                ADDR_W'(ADDR_TIMING2): begin
                    cfg_reg.reset_low_time <= pwdata_in[TIM2_RSTL_LSB +: 16];
                    cfg_reg.presence_sample_time <=
                        pwdata_in[TIM2_MSP_LSB +: 16];
                end
                default: cfg_reg <= cfg_reg;
            endcase
        end
    end

    always_ff @(posedge clk_in) begin
        if (reset_in) begin
            prdata_reg <= 32'h00000000;
        end else if (psel_in && !penable_in) begin
            prdata_reg <= 32'h00000000;
            case (paddr_in)
                ADDR_W'(ADDR_CTRL): begin
                    prdata_reg[CTRL_OD] <= cfg_reg.overdrive_speed_select;
                    prdata_reg[CTRL_ACT_PU] <= cfg_reg.active_pullup_enable;
                    prdata_reg[CTRL_PAS_PU] <= cfg_reg.passive_pullup_select;
                end
                ADDR_W'(ADDR_TIMING): begin
                    prdata_reg[TIM_W0L_LSB +: 12] <=
                        cfg_reg.write_zero_low_time;
                    prdata_reg[TIM_REC_LSB +: 12] <= cfg_reg.recovery_time;
                end
                ADDR_W'(ADDR_TIMING2): begin
                    prdata_reg[TIM2_RSTL_LSB +: 16] <= cfg_reg.reset_low_time;
                    prdata_reg[TIM2_MSP_LSB +: 16] <=
                        cfg_reg.presence_sample_time;
                end
                ADDR_W'(ADDR_STATUS): begin
                    prdata_reg[7:0] <= status_byte(status_reg);
                end
                default: prdata_reg <= 32'h00000000;
            endcase
        end
    end

    // ---------------------------------------------------------------
    // assertions
    // ---------------------------------------------------------------
    logic [15:0] run_cyc_reg;
    always_ff @(posedge clk_in) begin
        if (reset_in || start_run) begin
            run_cyc_reg <= 16'h0000;
        end else if (status_reg.line_busy_flag) begin
            run_cyc_reg <= run_cyc_reg + 16'h0001;
        end
    end

    default clocking cb @(posedge clk_in); endclocking
    default disable iff (reset_in);

    property p_code_nack_busy;
        host_byte_in && host_write_in && phase_reg == PH_CODE &&
        status_reg.line_busy_flag |-> !host_ack_out;
    endproperty
    a_code_nack_busy: assert property (p_code_nack_busy) // [R7]
        else $error("code acked while busy");

    property p_param_dropped;
        host_byte_in && host_write_in && phase_reg == PH_DROP
        |-> !host_ack_out;
    endproperty
    a_param_dropped: assert property (p_param_dropped) // [R7]
        else $error("parameter acked after refused code");

    property p_surplus_nack;
        host_byte_in && host_write_in && phase_reg == PH_SURPLUS
        |-> !host_ack_out;
    endproperty
    a_surplus_nack: assert property (p_surplus_nack) // [R17]
        else $error("surplus byte acked");

    property p_fast_start;
        start_run |-> ##[1:6] line_oe_out;
    endproperty
    a_fast_start: assert property (p_fast_start) // [R9]
        else $error("line activity started late");

    property p_duration;
        status_reg.line_busy_flag |->
            run_cyc_reg <= 16'(3 * STD_SLOT_CYC + 3 * 4096 + ACT_DELAY_CYC);
    endproperty
    a_duration: assert property (p_duration) // [R8]
        else $error("triplet ran too long");

    property p_three_slots;
        $fell(status_reg.line_busy_flag) |-> $past(slot_reg) == 2'd2 &&
            state_reg == ST_IDLE;
    endproperty
    a_three_slots: assert property (p_three_slots) // [R2]
        else $error("busy fell before third slot");

    property p_busy_set;
        start_run |=> status_reg.line_busy_flag && ptr_status_reg;
    endproperty
    a_busy_set: assert property (p_busy_set) // [R11]
        else $error("busy not set at launch");

    property p_first_bit;
        sample_now && slot_reg == 2'd0 |=>
            status_reg.single_bit_result == $past(line_in);
    endproperty
    a_first_bit: assert property (p_first_bit) // [R12]
        else $error("first result not captured");

    property p_second_bit;
        sample_now && slot_reg == 2'd1 |=>
            status_reg.triplet_second_bit == $past(line_in);
    endproperty
    a_second_bit: assert property (p_second_bit) // [R13]
        else $error("second result not captured");

    property p_both_zero;
        sample_now && slot_reg == 2'd1 && !line_in &&
        !status_reg.single_bit_result |=>
            status_reg.chosen_dir == dir_pref_reg;
    endproperty
    a_both_zero: assert property (p_both_zero) // [R3]
        else $error("preferred branch not taken");

    property p_zero_one;
        sample_now && slot_reg == 2'd1 && line_in &&
        !status_reg.single_bit_result |=> !status_reg.chosen_dir;
    endproperty
    a_zero_one: assert property (p_zero_one) // [R4]
        else $error("zero path not chosen");

    property p_one_x;
        sample_now && slot_reg == 2'd1 &&
        status_reg.single_bit_result |=> status_reg.chosen_dir;
    endproperty
    a_one_x: assert property (p_one_x) // [R5]
        else $error("one path not chosen");

    property p_write_zero_low;
        state_reg == ST_RUN && slot_reg == 2'd2 && cnt_reg == 13'h0000 &&
        !status_reg.chosen_dir |-> line_oe_out && !line_out;
    endproperty
    a_write_zero_low: assert property (p_write_zero_low) // [R19]
        else $error("write slot does not start low");

    c_run: cover property ($fell(status_reg.line_busy_flag));
    c_refused: cover property (host_byte_in && phase_reg == PH_DROP);
    c_error_case: cover property (sample_now && slot_reg == 2'd1 && line_in &&
                                  status_reg.single_bit_result);
endmodule // swst_triplet

// >>> dv/swst_line_slave.sv
// single-wire slave model answering two read slots
`timescale 1ns/100ps
module swst_line_slave (
    // clock and control
    input wire logic clk_in,
    input wire logic clear_in,
    input wire logic [1:0] bits_in,
    // line
    input wire logic line_oe_in,
    input wire logic line_drv_in,
    output logic pull_low_out,
    // observation
    output logic [1:0] slot_count_out,
    output logic written_out
);
    int hold = 0;
    int low_len = 0;
    logic low_q = 1'b0;
    logic low;
    assign low = line_oe_in && !line_drv_in;
    assign pull_low_out = hold > 0;
    initial begin
        slot_count_out = 2'h0;
        written_out = 1'b0;
    end
    always @(posedge clk_in) begin
        low_q <= low;
        if (hold > 0) hold <= hold - 1;
        if (low) low_len <= low_len + 1;
        if (clear_in) slot_count_out <= 2'h0;
        if (low && !low_q) begin
            low_len <= 1;
            slot_count_out <= slot_count_out + 2'h1;
            if (slot_count_out < 2'h2 && !bits_in[slot_count_out]) hold <= 60;
        end
        if (!low && low_q && slot_count_out == 2'h3) written_out <= low_len < 40;
    end
endmodule // swst_line_slave

// >>> dv/swst_triplet_tb_top.sv
// self-checking bench of the search triplet sequencer
`timescale 1ns/100ps
module swst_triplet_tb_top;
    import swst_pkg::*;
    logic clk_in = 0, reset_in = 1, psel = 0, penable = 0, pwrite = 0;
    logic [7:0] paddr = 8'h00, hdata = 8'h00;
    logic [31:0] pwdata = 32'h0, prdata, q;
    logic pready, pslverr, hstart = 0, hbyte = 0, hmsb = 0, hbit = 0, hwr = 1;
    logic ack, ptr, line_out, line_oe, ppu, pull, clr = 0, wr, e;
    logic [7:0] rdat;
    logic [1:0] bits = 2'h3, slots;
    swst_status_type st;
    int fails = 0, check_count = 0, cyc = 0, t0;
    always #20 clk_in = ~clk_in;
    swst_triplet swst_triplet_i (.clk_in(clk_in), .reset_in(reset_in),
        .psel_in(psel), .penable_in(penable), .pwrite_in(pwrite),
        .paddr_in(paddr), .pwdata_in(pwdata), .prdata_out(prdata),
        .pready_out(pready), .pslverr_out(pslverr), .host_start_in(hstart),
        .host_write_in(hwr), .host_msb_in(hmsb), .host_msb_bit_in(hbit),
        .host_byte_in(hbyte), .host_data_in(hdata), .host_ack_out(ack),
        .read_data_out(rdat), .read_ptr_status_out(ptr),
        .line_in(!(line_oe && !line_out) && !pull), .line_out(line_out),
        .line_oe_out(line_oe), .passive_pullup_select_out(ppu),
        .status_out(st));
    swst_line_slave swst_line_slave_i (.clk_in(clk_in), .clear_in(clr),
        .bits_in(bits), .line_oe_in(line_oe), .line_drv_in(line_out),
        .pull_low_out(pull), .slot_count_out(slots), .written_out(wr));
    task automatic wrap_up;
        if (fails == 0 && check_count > 0) $display("TEST PASSED");
        else $display("TEST FAILED");
        $finish;
    endtask
    always @(posedge clk_in) begin
        cyc <= cyc + 1;
        if (cyc > 20000) begin
            fails++;
            wrap_up();
        end
    end
    task automatic chk(string n, logic [31:0] x, logic [31:0] g);
        check_count++;
        if (g !== x) begin
            $display("wrong value %s expected %h seen %h", n, x, g);
            fails++;
        end
    endtask
    task automatic apb(logic w, logic [7:0] a, logic [31:0] d);
        @(posedge clk_in);
        psel <= 1; penable <= 0; pwrite <= w; paddr <= a; pwdata <= d;
        @(posedge clk_in);
        penable <= 1;
        @(posedge clk_in);
        while (pready !== 1'b1) @(posedge clk_in);
        q = prdata;
        e = pslverr;
        psel <= 0; penable <= 0;
    endtask
    task automatic hput(logic [7:0] d, logic a, logic s);
        @(posedge clk_in);
        hstart <= s;
        @(posedge clk_in);
        hstart <= 0; hbyte <= 1; hdata <= d;
        @(negedge clk_in);
        chk("host ack", 32'(a), 32'(ack));
        @(posedge clk_in);
        hbyte <= 0;
    endtask
    task automatic hmsb_pulse(logic v);
        @(posedge clk_in);
        hmsb <= 1; hbit <= v;
        @(posedge clk_in);
        hmsb <= 0;
    endtask
    task automatic trip(logic [1:0] rb, logic v, logic w);
        bits <= rb; clr <= 1;
        hput(CMD_TRIPLET, 1'b1, 1'b1);
        clr <= 0;
        hmsb_pulse(v);
        t0 = cyc;
        while (line_oe !== 1'b1 && cyc - t0 < 50) @(posedge clk_in);
        chk("line start", 1, 32'(cyc - t0 <= ACT_DELAY_CYC));
        hput({v, 7'h2A}, 1'b1, 1'b0);
        hput(8'h00, 1'b0, 1'b0);
        hput(CMD_TRIPLET, 1'b0, 1'b1);
        hmsb_pulse(1'b1);
        hput(8'h80, 1'b0, 1'b0);
        chk("busy", 1, 32'(st.line_busy_flag));
        while (st.line_busy_flag !== 1'b0 && cyc - t0 < 2000)
            @(posedge clk_in);
        chk("busy long", 1, 32'(cyc - t0 >= 3 * OD_SLOT_CYC));
        chk("busy end", 1, 32'(cyc - t0 <= 3 * OD_SLOT_CYC + 8));
        repeat (300) @(posedge clk_in);
        chk("slots", 3, 32'(slots));
        chk("written", 32'(w), 32'(wr));
        chk("first bit", 32'(rb[0]), 32'(st.single_bit_result));
        chk("second bit", 32'(rb[1]), 32'(st.triplet_second_bit));
        chk("dir", 32'(w), 32'(st.chosen_dir));
        chk("pointer", 1, 32'(ptr));
        chk("read byte", 32'({w, rb[1], rb[0]}), 32'(rdat[7:5]));
        apb(1'b0, ADDR_STATUS, 32'h0);
        chk("status reg", 32'({w, rb[1], rb[0], 5'h00}), q & 32'hE1);
    endtask
    initial begin
        repeat (2) @(posedge clk_in);
        reset_in <= 0;
        apb(1'b1, ADDR_TIMING, 32'h0005_0040);
        apb(1'b0, ADDR_TIMING, 32'h0);
        chk("timing", 32'h0005_0040, q);
        apb(1'b1, ADDR_CTRL, 32'h5);
        @(negedge clk_in);
        chk("pullup sel", 1, 32'(ppu));
        apb(1'b0, 8'h10, 32'h0);
        chk("unmapped err", 1, 32'(e));
        chk("unmapped data", 0, q);
        hwr <= 0;
        hput(CMD_TRIPLET, 1'b0, 1'b1);
        hwr <= 1;
        hput(8'h96, 1'b0, 1'b1);
        hput(8'h80, 1'b0, 1'b0);
        // host repeats the triplet per search bit
        trip(2'b00, 1'b1, 1'b1);
        trip(2'b00, 1'b0, 1'b0);
        trip(2'b10, 1'b1, 1'b0);
        trip(2'b01, 1'b0, 1'b1);
        trip(2'b11, 1'b0, 1'b1);
        apb(1'b1, ADDR_CTRL, 32'h7);
        trip(2'b00, 1'b0, 1'b0);
        trip(2'b01, 1'b1, 1'b1);
        wrap_up();
    end
endmodule // swst_triplet_tb_top
